// *** rtl/ep_pkg.sv ***
// Constants, state codes and carrier types for the two-wire memory target
package ep_pkg;
   localparam int MEM_BYTES = 256;
   localparam int PAGE_BYTES = 8;
   localparam int PAGES = MEM_BYTES / PAGE_BYTES;
   localparam logic [3:0] DEV_TYPE = 4'hA;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam int CLK_HZ = 10000000;
   localparam int T_WR_MS = 5;
   // Longest time, so the count rounds down
   localparam int T_WR_CYC = (T_WR_MS * CLK_HZ) / 1000;
   localparam int TMR_W = 16;
   localparam int SYNC_W = 7;
   localparam int LN_SDA = 0;
   localparam int LN_SCL = 1;
   localparam int LN_TGL = 2;
   localparam int LN_WP = 3;
   localparam int LN_SEL = 4;
   localparam logic [SYNC_W-1:0] SYNC_RST = 7'h03;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_DEV   = 6'h02,
      ST_WADDR = 6'h04,
      ST_WDATA = 6'h08,
      ST_RDATA = 6'h10,
      ST_PROG  = 6'h20
   } ep_state_t;

   typedef struct packed {
      logic start;
      logic stop;
      logic bit_ev;
      logic bit_val;
   } ep_ev_t;
endpackage : ep_pkg

// *** rtl/ep_target.sv ***
// Two-wire serial target with 256-byte paged array and timed programming
// Function
// - Sample on rising clock, drive on falling
// - Data line only pulled low or released
// - Bus identity from three tied select inputs
// - Protect low: whole array reads and writes
// - Protect high: upper half never changes
// - 32 pages of 8 bytes, upper bits
// - One address byte selects any location
// - Timed programming finishes within 5 ms
// - Partial pages change only received bytes
// - Start/stop are data edges, clock high
// - Select mismatch returns device to standby
// - Acknowledge each received byte on ninth clock
// - Page write wraps low three address bits
`timescale 1ns/1ps
module ep_target
#(
   parameter int T_WR = ep_pkg::T_WR_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl_clk,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [2:0] bus_select_inputs,
   input wire logic write_protect
);
   import ep_pkg::*;

   // Link side: sample on rising clock, toggle marks a new bit
   logic smp_q, tgl_q, oe_q, sda_o_q;
   always_ff @(posedge scl_clk or posedge rst) begin
      if (rst) begin
         smp_q <= 1'b0;
         tgl_q <= 1'b0;
      end else begin
         smp_q <= sda_i;
         tgl_q <= ~tgl_q;
      end
   end

   // Drive level is held steady by the system side across the falling edge
   logic drive_q, drive_d;
   always_ff @(negedge scl_clk or posedge rst) begin
      if (rst) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= drive_q;
      end
   end
   assign sda_oe = oe_q;

   always_ff @(posedge clk_sys) begin
      sda_o_q <= 1'b0;
   end
   assign sda_o = sda_o_q;

   // Pin and toggle synchronisers, a change counts once stages two and three agree
   logic [SYNC_W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, raw;
   assign raw = {bus_select_inputs, write_protect, tgl_q, scl_clk, sda_i};
   always_comb begin
      for (int i = 0; i < SYNC_W; i++) begin
         lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s1_q <= SYNC_RST;
         s2_q <= SYNC_RST;
         s3_q <= SYNC_RST;
         lvl_q <= SYNC_RST;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   ep_ev_t ev;
   wire logic wp_lvl = lvl_q[LN_WP];
   wire logic [2:0] sel_lvl = lvl_q[LN_SEL +: 3];
   always_comb begin
      ev.start = lvl_q[LN_SCL] && lvl_q[LN_SDA] && !lvl_d[LN_SDA] && lvl_d[LN_SCL];
      ev.stop = lvl_q[LN_SCL] && !lvl_q[LN_SDA] && lvl_d[LN_SDA] && lvl_d[LN_SCL];
      ev.bit_ev = lvl_q[LN_TGL] ^ lvl_d[LN_TGL];
      ev.bit_val = smp_q;
   end

   // Protocol state
   logic [7:0] mem [MEM_BYTES];
   logic [7:0] pbuf_q [PAGE_BYTES], pbuf_d [PAGE_BYTES];
   ep_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, addr_q, addr_d, byte_in, rd_byte;
   logic [PAGE_BYTES-1:0] val_q, val_d, we;
   logic rw_q, rw_d, tmr_end, prot;
   logic [TMR_W-1:0] tmr_q, tmr_d;

   assign byte_in = {sh_q[6:0], ev.bit_val};
   assign rd_byte = mem[addr_q];
   assign tmr_end = (st_q == ST_PROG) && (tmr_q == TMR_W'(T_WR - 1));
   assign prot = wp_lvl && addr_q[7];
   // Commit only received bytes, and none of a protected page
   assign we = (tmr_end && !prot) ? val_q : '0;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      addr_d = addr_q;
      val_d = val_q;
      rw_d = rw_q;
      drive_d = drive_q;
      tmr_d = tmr_q;
      pbuf_d = pbuf_q;
      if (ev.bit_ev && st_q != ST_PROG && st_q != ST_IDLE) begin
         cnt_d = (cnt_q == BIT_ACK) ? 4'h0 : cnt_q + 4'h1;
         if (st_q != ST_RDATA) begin
            sh_d = byte_in;
         end
      end
      case (st_q)
         ST_IDLE: begin
            drive_d = 1'b0;
         end
         ST_DEV: begin
            if (ev.bit_ev && cnt_q == BIT_LAST) begin
               if (byte_in[7:4] == DEV_TYPE && byte_in[3:1] == sel_lvl) begin
                  drive_d = 1'b1;
                  rw_d = byte_in[0];
               end else begin
                  st_d = ST_IDLE;
               end
            end else if (ev.bit_ev && cnt_q == BIT_ACK) begin
               if (rw_q) begin
                  st_d = ST_RDATA;
                  sh_d = rd_byte;
                  addr_d = addr_q + 8'h01;
                  drive_d = ~rd_byte[7];
               end else begin
                  st_d = ST_WADDR;
                  drive_d = 1'b0;
               end
            end
         end
         ST_WADDR: begin
            if (ev.bit_ev && cnt_q == BIT_LAST) begin
               addr_d = byte_in;
               drive_d = 1'b1;
            end else if (ev.bit_ev && cnt_q == BIT_ACK) begin
               st_d = ST_WDATA;
               drive_d = 1'b0;
            end
         end
         ST_WDATA: begin
            if (ev.bit_ev && cnt_q == BIT_LAST) begin
               pbuf_d[addr_q[2:0]] = byte_in;
               val_d[addr_q[2:0]] = 1'b1;
               addr_d = {addr_q[7:3], addr_q[2:0] + 3'h1};
               drive_d = 1'b1;
            end else if (ev.bit_ev && cnt_q == BIT_ACK) begin
               drive_d = 1'b0;
            end
         end
         ST_RDATA: begin
            if (ev.bit_ev && cnt_q < BIT_LAST) begin
               sh_d = {sh_q[6:0], 1'b0};
               drive_d = ~sh_q[6];
            end else if (ev.bit_ev && cnt_q == BIT_LAST) begin
               drive_d = 1'b0;
            end else if (ev.bit_ev && cnt_q == BIT_ACK) begin
               if (!ev.bit_val) begin
                  sh_d = rd_byte;
                  addr_d = addr_q + 8'h01;
                  drive_d = ~rd_byte[7];
               end else begin
                  st_d = ST_IDLE;
               end
            end
         end
         ST_PROG: begin
            // No clock needed; bus ignored until the cycle ends
            drive_d = 1'b0;
            tmr_d = tmr_q + TMR_W'(1);
            if (tmr_end) begin
               st_d = ST_IDLE;
               val_d = '0;
               tmr_d = '0;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      if (st_q != ST_PROG) begin
         if (ev.start) begin
            st_d = ST_DEV;
            cnt_d = 4'h0;
            drive_d = 1'b0;
            val_d = '0;
         end else if (ev.stop) begin
            st_d = (st_q == ST_WDATA && val_q != '0) ? ST_PROG : ST_IDLE;
            drive_d = 1'b0;
            tmr_d = '0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         addr_q <= 8'h00;
         val_q <= '0;
         rw_q <= 1'b0;
         drive_q <= 1'b0;
         tmr_q <= '0;
         pbuf_q <= '{default: 8'h00};
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         addr_q <= addr_d;
         val_q <= val_d;
         rw_q <= rw_d;
         drive_q <= drive_d;
         tmr_q <= tmr_d;
         pbuf_q <= pbuf_d;
      end
   end

   // Array content is nonvolatile, so it has no reset
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
         if (we[i]) begin
            mem[{addr_q[7:3], 3'(i)}] <= pbuf_q[i];
         end
      end
   end

   // Checks
   sequence s_byte_done(ep_state_t s);
      ev.bit_ev && cnt_q == BIT_LAST && st_q == s && !ev.start && !ev.stop;
   endsequence

   property p_mismatch_idle;
      @(posedge clk_sys) disable iff (rst)
      s_byte_done(ST_DEV) and (byte_in[3:1] != sel_lvl) |=> st_q == ST_IDLE && !drive_q;
   endproperty
   a_mismatch_idle: assert property (p_mismatch_idle) else $error("select mismatch not idle");
   property p_ack_drive;
      @(posedge clk_sys) disable iff (rst)
      (s_byte_done(ST_WADDR) or s_byte_done(ST_WDATA)) |=> drive_q;
   endproperty
   a_ack_drive: assert property (p_ack_drive) else $error("received byte not acknowledged");
   property p_page_wrap;
      @(posedge clk_sys) disable iff (rst)
      s_byte_done(ST_WDATA) |=> addr_q[7:3] == $past(addr_q[7:3])
         && addr_q[2:0] == $past(addr_q[2:0]) + 3'h1;
   endproperty
   a_page_wrap: assert property (p_page_wrap) else $error("page address not wrapped");
   property p_addr_load;
      @(posedge clk_sys) disable iff (rst)
      s_byte_done(ST_WADDR) |=> addr_q == $past(byte_in);
   endproperty
   a_addr_load: assert property (p_addr_load) else $error("word address not loaded");
   property p_prog_bound;
      @(posedge clk_sys) disable iff (rst)
      st_q == ST_PROG |-> tmr_q < TMR_W'(T_WR);
   endproperty
   a_prog_bound: assert property (p_prog_bound) else $error("programming overran");
   property p_prog_end;
      @(posedge clk_sys) disable iff (rst)
      tmr_end |=> st_q == ST_IDLE && val_q == '0;
   endproperty
   a_prog_end: assert property (p_prog_end) else $error("programming did not end");
   property p_protect;
      @(posedge clk_sys) disable iff (rst)
      wp_lvl && addr_q[7] |-> we == '0;
   endproperty
   a_protect: assert property (p_protect) else $error("protected half written");
   property p_partial;
      @(posedge clk_sys) disable iff (rst)
      (we & ~val_q) == '0 and (tmr_end && !wp_lvl |-> we == val_q);
   endproperty
   a_partial: assert property (p_partial) else $error("wrong bytes committed");
   property p_start;
      @(posedge clk_sys) disable iff (rst)
      ev.start && st_q != ST_PROG |=> st_q == ST_DEV && cnt_q == 4'h0;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
endmodule : ep_target

// *** test/ep_ctrl.sv ***
// Two-wire bus controller model: serial clock and open-drain data pull
`timescale 1ns/1ps
module ep_ctrl (
   output logic scl_clk,
   output logic sda_pull,
   input wire logic sda
);
   localparam int Q = 500;
   initial begin
      scl_clk = 1'b1;
      sda_pull = 1'b0;
   end
   // Clock stands high between frames; data bits move only while it is low
   task automatic bit_out(input logic b, output logic s);
      #Q sda_pull = ~b;
      #Q scl_clk = 1'b1;
      #Q s = sda;
      #Q scl_clk = 1'b0;
   endtask : bit_out
   task automatic start();
      #Q sda_pull = 1'b0;
      #Q scl_clk = 1'b1;
      #Q sda_pull = 1'b1;
      #Q scl_clk = 1'b0;
   endtask : start
   task automatic stop();
      #Q sda_pull = 1'b1;
      #Q scl_clk = 1'b1;
      #Q sda_pull = 1'b0;
      #Q;
   endtask : stop
   task automatic wbyte(input logic [7:0] d, output logic ak);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i], s);
      end
      bit_out(1'b1, s);
      ak = ~s;
   endtask : wbyte
   // Last byte gets no acknowledge so the target lets go
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_out(1'b1, s);
         d[i] = s;
      end
      bit_out(last, s);
   endtask : rbyte
endmodule : ep_ctrl

// *** test/ep_target_tb.sv ***
// Self-checking bench for the two-wire memory target
`timescale 1ns/1ps
module ep_target_tb;
   import ep_pkg::*;
   localparam int PROGRAMMING_CYCLE_TIME = 200;
   logic clk_sys = 1'b0;
   logic rst = 1'b0;
   logic write_protect = 1'b0;
   logic [2:0] bus_select_inputs = 3'h5;
   logic scl_clk, sda_pull, sda_o, sda_oe, ak;
   wire logic sda = ~(sda_pull | (sda_oe & ~sda_o));
   int seed = 32'h3B55208E;
   int fail_count = 0;
   int samples_checked = 0;
   int mem [MEM_BYTES];
   bit known [MEM_BYTES];
   always #50 clk_sys = ~clk_sys;
   ep_target #(.T_WR(PROGRAMMING_CYCLE_TIME)) dut (.clk_sys(clk_sys), .rst(rst), .scl_clk(scl_clk),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .bus_select_inputs(bus_select_inputs), .write_protect(write_protect));
   ep_ctrl ctl (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda(sda));
   task automatic wrap_up();
      $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   task automatic chk_ack(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t ack %b not %b", $time, got, exp);
      end
   endtask : chk_ack
   task automatic chk_byte(input logic [7:0] got, input int exp);
      samples_checked++;
      if (got !== exp[7:0]) begin
         fail_count++;
         $display("MISMATCH %0t read %h not %h", $time, got, exp[7:0]);
      end
   endtask : chk_byte
   task automatic drive(input logic wp, input logic [2:0] sel);
      @(posedge clk_sys);
      #5;
      write_protect = wp;
      bus_select_inputs = sel;
   endtask : drive
   task automatic wr(input logic [7:0] a, input int n);
      logic [7:0] d;
      logic [7:0] w;
      int tries;
      ctl.start();
      ctl.wbyte({DEV_TYPE, bus_select_inputs, 1'b0}, ak);
      chk_ack(ak, 1'b1);
      ctl.wbyte(a, ak);
      chk_ack(ak, 1'b1);
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         w = {a[7:3], 3'(a[2:0] + i)};
         ctl.wbyte(d, ak);
         chk_ack(ak, 1'b1);
         if (!(write_protect && w[7])) begin
            mem[w] = d;
            known[w] = 1'b1;
         end
      end
      ctl.stop();
      tries = 0;
      ak = 1'b0;
      // Bounded acknowledge polling while the array programs
      while (ak !== 1'b1 && tries < 5) begin
         ctl.start();
         ctl.wbyte({DEV_TYPE, bus_select_inputs, 1'b0}, ak);
         tries++;
      end
      ctl.stop();
      chk_ack(tries > 1, 1'b1);
      chk_ack(ak, 1'b1);
      if (ak !== 1'b1) begin
         wrap_up();
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, input int n);
      logic [7:0] d;
      logic [7:0] r;
      ctl.start();
      ctl.wbyte({DEV_TYPE, bus_select_inputs, 1'b0}, ak);
      ctl.wbyte(a, ak);
      chk_ack(ak, 1'b1);
      ctl.start();
      ctl.wbyte({DEV_TYPE, bus_select_inputs, 1'b1}, ak);
      chk_ack(ak, 1'b1);
      for (int i = 0; i < n; i++) begin
         r = 8'(a + i);
         ctl.rbyte(i == n - 1, d);
         if (known[r]) begin
            chk_byte(d, mem[r]);
         end
      end
      ctl.stop();
   endtask : rd
   initial begin
      #9000000;
      fail_count++;
      $display("MISMATCH %0t run timed out", $time);
      wrap_up();
   end
   initial begin
      // Real rising edge, so the link-side flops take their asynchronous reset
      #1 rst = 1'b1;
      repeat (12) @(posedge clk_sys);
      #5 rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #37;
      wr(8'h13, 3);
      wr(8'hA6, 10);
      wr(8'hFD, 3);
      wr(8'h00, 2);
      rd(8'h10, 8);
      rd(8'hA0, 8);
      rd(8'hFD, 5);
      $display("Writes and reads done");
      drive(1'b0, 3'($random(seed)));
      for (int s = 0; s < 8; s++) begin
         ctl.start();
         ctl.wbyte({DEV_TYPE, 3'(s), 1'b0}, ak);
         chk_ack(ak, 3'(s) == bus_select_inputs);
         ctl.stop();
      end
      $display("Select test done");
      drive(1'b1, bus_select_inputs);
      wr(8'hA2, 4);
      wr(8'h14, 2);
      rd(8'hA0, 8);
      rd(8'h10, 8);
      $display("Protect test done");
      wrap_up();
   end
endmodule : ep_target_tb
